// >>> hdl/dofs_pkg.sv
package dofs_pkg;

    // data widths
    localparam int          MEAS_W          = 16;
    localparam int          DEN_W           = 18;
    localparam int          ADDR_W          = 8;

    // register byte offsets
    localparam logic [7:0]  OFS_FUNC_SEL    = 8'h00;
    localparam logic [7:0]  OFS_UPPER_THR   = 8'h04;
    localparam logic [7:0]  OFS_LOWER_THR   = 8'h08;
    localparam logic [7:0]  OFS_RATED_CUR   = 8'h0C;
    localparam logic [7:0]  OFS_MAX_FREQ    = 8'h10;
    localparam logic [7:0]  OFS_RATED_TRQ   = 8'h14;
    localparam logic [7:0]  OFS_RATED_PWR   = 8'h18;
    localparam logic [7:0]  OFS_STATUS      = 8'h1C;
    localparam logic [7:0]  OFS_ANALOG      = 8'h20;

    // reset values
    localparam logic [3:0]  RST_FUNC_SEL    = 4'h0;
    localparam logic [15:0] RST_UPPER_THR   = 16'h0000;
    localparam logic [15:0] RST_LOWER_THR   = 16'h0000;
    localparam logic [15:0] RST_RATED_CUR   = 16'h0000;
    localparam logic [15:0] RST_MAX_FREQ    = 16'h0000;
    localparam logic [15:0] RST_RATED_TRQ   = 16'h0000;
    localparam logic [15:0] RST_RATED_PWR   = 16'h0000;

    // status register field positions
    localparam int          STS_DIG_BIT     = 0;
    localparam int          STS_HYST_BIT    = 1;
    localparam int          STS_BUSY_BIT    = 2;

    // full-scale analog code and axi responses
    localparam logic [15:0] FULL_SCALE      = 16'hFFFF;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [3:0]  DIV_LAST        = 4'hF;

    typedef enum logic [3:0] {
        FN_ENABLED   = 4'h0,
        FN_HEALTHY   = 4'h1,
        FN_AT_TARGET = 4'h2,
        FN_RUNNING   = 4'h3,
        FN_FREQ_LIM  = 4'h4,
        FN_CUR_LIM   = 4'h5,
        FN_TRQ_LIM   = 4'h6,
        FN_AIN2_LIM  = 4'h7,
        FN_A_FREQ    = 4'h8,
        FN_A_CUR     = 4'h9,
        FN_A_TRQ     = 4'hA,
        FN_A_PWR     = 4'hB,
        FN_A_PID     = 4'hC
    } dofs_func_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_DONE = 2'b11
    } dofs_div_st_t;

    // internal drive measurements
    typedef struct packed {
        logic        running;
        logic        fault;
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic [15:0] motor_cur;
        logic [15:0] motor_trq;
        logic [15:0] ain2;
        logic [15:0] out_pwr;
        logic [15:0] pid_out;
    } dofs_meas_t;

    // software configuration
    typedef struct packed {
        logic [3:0]  func_sel;
        logic [15:0] upper_switch_threshold;
        logic [15:0] lower_switch_threshold;
        logic [15:0] motor_rated_current;
        logic [15:0] max_freq;
        logic [15:0] rated_trq;
        logic [15:0] rated_pwr;
    } dofs_cfg_t;

endpackage : dofs_pkg

// >>> hdl/dofs_hyst.sv
`timescale 1ns/100ps
module dofs_hyst (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        enable,
    input  wire logic [15:0] sig,
    input  wire logic [15:0] upper_switch_threshold,
    input  wire logic [15:0] lower_switch_threshold,
    output logic             state
);
    logic state_r;
    logic state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (!enable) begin
            state_nxt = 1'b0;
        end else if (!state_r && sig >= upper_switch_threshold) begin
            state_nxt = 1'b1;
        end else if (state_r && sig < lower_switch_threshold) begin
            state_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign state = state_r;
endmodule : dofs_hyst

// >>> hdl/dofs_scale.sv
`timescale 1ns/100ps
module dofs_scale (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic [15:0] num,
    input  wire logic [17:0] den,
    output logic             busy,
    output logic             done,
    output logic [15:0]      quo
);
    // quo = num * 65536 / den, saturated to full scale
    dofs_pkg::dofs_div_st_t st_r, st_nxt;
    logic [18:0] rem_r, rem_nxt;
    logic [17:0] den_r, den_nxt;
    logic [15:0] q_r, q_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [18:0] rem2;

    always_comb begin
        st_nxt  = st_r;
        rem_nxt = rem_r;
        den_nxt = den_r;
        q_nxt   = q_r;
        cnt_nxt = cnt_r;
        rem2    = {rem_r[17:0], 1'b0};
        case (st_r)
            dofs_pkg::DIV_IDLE: begin
                if (start) begin
                    den_nxt = den;
                    rem_nxt = {3'b000, num};
                    cnt_nxt = 4'h0;
                    q_nxt   = 16'h0000;
                    if (num == 16'h0000) begin
                        st_nxt = dofs_pkg::DIV_DONE;
                    end else if ({2'b00, num} >= den) begin
                        q_nxt  = dofs_pkg::FULL_SCALE;
                        st_nxt = dofs_pkg::DIV_DONE;
                    end else begin
                        st_nxt = dofs_pkg::DIV_RUN;
                    end
                end
            end
            dofs_pkg::DIV_RUN: begin
                if (rem2 >= {1'b0, den_r}) begin
                    rem_nxt = rem2 - {1'b0, den_r};
                    q_nxt   = {q_r[14:0], 1'b1};
                end else begin
                    rem_nxt = rem2;
                    q_nxt   = {q_r[14:0], 1'b0};
                end
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == dofs_pkg::DIV_LAST) begin
                    st_nxt = dofs_pkg::DIV_DONE;
                end
            end
            dofs_pkg::DIV_DONE: begin
                st_nxt = dofs_pkg::DIV_IDLE;
            end
            default: begin
                st_nxt = dofs_pkg::DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_r  <= dofs_pkg::DIV_IDLE;
            rem_r <= 19'h0_0000;
            den_r <= 18'h0_0000;
            q_r   <= 16'h0000;
            cnt_r <= 4'h0;
        end else begin
            st_r  <= st_nxt;
            rem_r <= rem_nxt;
            den_r <= den_nxt;
            q_r   <= q_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign busy = (st_r != dofs_pkg::DIV_IDLE);
    assign done = (st_r == dofs_pkg::DIV_DONE);
    assign quo  = q_r;
endmodule : dofs_scale

// >>> hdl/dofs_top.sv
// Notes on behaviour
// - code 2: output high exactly when output frequency equals the setpoint
// - code 3: output high when output frequency is above zero
// - code 4: output asserts when output frequency reaches the limit, via thresholds
// - code 5: output asserts when motor current reaches the limit, via thresholds
// - code 6: output asserts when motor torque reaches the limit, via thresholds
// - code 7: output asserts when second analog input reaches the limit
// - codes 4 to 7: output goes high when signal reaches upper threshold
// - codes 4 to 7: output stays high until signal drops below lower threshold
// - code 9: analog full scale equals twice motor rated current
// - code 10: analog full scale equals twice rated torque
// - code 11: analog full scale equals one and a half times rated power
// - code 12: analog output carries the internal pid controller output
// - code 0: output high while the drive is enabled and running
// - code 1: output high while no fault is present
`timescale 1ns/100ps
module dofs_top (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire dofs_pkg::dofs_meas_t meas,
    output logic                      dig_out,
    output logic [15:0]               ana_out,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    // configuration registers
    dofs_pkg::dofs_cfg_t cfg_r, cfg_nxt;

    // write channel state
    logic        aw_held_r, aw_held_nxt;
    logic        w_held_r, w_held_nxt;
    logic [7:0]  waddr_r, waddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        do_write;
    logic        wmapped;

    // read channel state
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    // output state
    logic        dig_r, dig_nxt;
    logic [15:0] ana_r, ana_nxt;
    // selection logic
    logic        hyst_en;
    logic        hyst_state;
    logic [15:0] hyst_sig;
    logic        scaled;
    logic [15:0] scale_num;
    logic [17:0] scale_den;
    logic        scale_busy;
    logic        scale_done;
    logic [15:0] scale_quo;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // comparison signal for the threshold codes
    always_comb begin
        hyst_en  = 1'b1;
        hyst_sig = 16'h0000;
        case (cfg_r.func_sel)
            dofs_pkg::FN_FREQ_LIM: hyst_sig = meas.out_freq;
            dofs_pkg::FN_CUR_LIM:  hyst_sig = meas.motor_cur;
            dofs_pkg::FN_TRQ_LIM:  hyst_sig = meas.motor_trq;
            dofs_pkg::FN_AIN2_LIM: hyst_sig = meas.ain2;
            default:               hyst_en  = 1'b0;
        endcase
    end

    dofs_hyst u_hyst (
        .clk_sys                (clk_sys),
        .resetn                 (resetn),
        .enable                 (hyst_en),
        .sig                    (hyst_sig),
        .upper_switch_threshold (cfg_r.upper_switch_threshold),
        .lower_switch_threshold (cfg_r.lower_switch_threshold),
        .state                  (hyst_state)
    );

    // numerator and full-scale value for analog codes 8 to 11
    always_comb begin
        scaled    = 1'b1;
        scale_num = 16'h0000;
        scale_den = 18'h0_0000;
        case (cfg_r.func_sel)
            dofs_pkg::FN_A_FREQ: begin
                scale_num = meas.out_freq;
                scale_den = {2'b00, cfg_r.max_freq};
            end
            dofs_pkg::FN_A_CUR: begin
                scale_num = meas.motor_cur;
                scale_den = {1'b0, cfg_r.motor_rated_current, 1'b0};
            end
            dofs_pkg::FN_A_TRQ: begin
                scale_num = meas.motor_trq;
                scale_den = {1'b0, cfg_r.rated_trq, 1'b0};
            end
            dofs_pkg::FN_A_PWR: begin
                scale_num = meas.out_pwr;
                scale_den = {2'b00, cfg_r.rated_pwr}
                          + {3'b000, cfg_r.rated_pwr[15:1]};
            end
            default: scaled = 1'b0;
        endcase
    end

    dofs_scale u_scale (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .start   (scaled),
        .num     (scale_num),
        .den     (scale_den),
        .busy    (scale_busy),
        .done    (scale_done),
        .quo     (scale_quo)
    );

    // output selection
    always_comb begin
        dig_nxt = 1'b0;
        ana_nxt = ana_r;
        case (cfg_r.func_sel)
            dofs_pkg::FN_ENABLED: begin
                dig_nxt = meas.running;
                ana_nxt = 16'h0000;
            end
            dofs_pkg::FN_HEALTHY: begin
                dig_nxt = !meas.fault;
                ana_nxt = 16'h0000;
            end
            dofs_pkg::FN_AT_TARGET: begin
                dig_nxt = (meas.out_freq == meas.set_freq);
                ana_nxt = 16'h0000;
            end
            dofs_pkg::FN_RUNNING: begin
                dig_nxt = (meas.out_freq != 16'h0000);
                ana_nxt = 16'h0000;
            end
            dofs_pkg::FN_FREQ_LIM,
            dofs_pkg::FN_CUR_LIM,
            dofs_pkg::FN_TRQ_LIM,
            dofs_pkg::FN_AIN2_LIM: begin
                dig_nxt = hyst_state;
                ana_nxt = 16'h0000;
            end
            dofs_pkg::FN_A_FREQ,
            dofs_pkg::FN_A_CUR,
            dofs_pkg::FN_A_TRQ,
            dofs_pkg::FN_A_PWR: begin
                if (scale_done) begin
                    ana_nxt = scale_quo;
                end
            end
            dofs_pkg::FN_A_PID: ana_nxt = meas.pid_out;
            default:            ana_nxt = 16'h0000;
        endcase
    end

    // axi4-lite write path: address and data taken in either order
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wmapped  = (waddr_r == dofs_pkg::OFS_FUNC_SEL)
                   || (waddr_r == dofs_pkg::OFS_UPPER_THR)
                   || (waddr_r == dofs_pkg::OFS_LOWER_THR)
                   || (waddr_r == dofs_pkg::OFS_RATED_CUR)
                   || (waddr_r == dofs_pkg::OFS_MAX_FREQ)
                   || (waddr_r == dofs_pkg::OFS_RATED_TRQ)
                   || (waddr_r == dofs_pkg::OFS_RATED_PWR);

    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        waddr_nxt   = waddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        cfg_nxt     = cfg_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            waddr_nxt   = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wmapped ? dofs_pkg::RESP_OKAY : dofs_pkg::RESP_SLVERR;
            case (waddr_r)
                dofs_pkg::OFS_FUNC_SEL: begin
                    if (wstrb_r[0]) begin
                        cfg_nxt.func_sel = wdata_r[3:0];
                    end
                end
                dofs_pkg::OFS_UPPER_THR: begin
                    cfg_nxt.upper_switch_threshold =
                        merge16(cfg_r.upper_switch_threshold, wdata_r, wstrb_r);
                end
                dofs_pkg::OFS_LOWER_THR: begin
                    cfg_nxt.lower_switch_threshold =
                        merge16(cfg_r.lower_switch_threshold, wdata_r, wstrb_r);
                end
                dofs_pkg::OFS_RATED_CUR: begin
                    cfg_nxt.motor_rated_current =
                        merge16(cfg_r.motor_rated_current, wdata_r, wstrb_r);
                end
                dofs_pkg::OFS_MAX_FREQ: begin
                    cfg_nxt.max_freq = merge16(cfg_r.max_freq, wdata_r, wstrb_r);
                end
                dofs_pkg::OFS_RATED_TRQ: begin
                    cfg_nxt.rated_trq = merge16(cfg_r.rated_trq, wdata_r, wstrb_r);
                end
                dofs_pkg::OFS_RATED_PWR: begin
                    cfg_nxt.rated_pwr = merge16(cfg_r.rated_pwr, wdata_r, wstrb_r);
                end
                default: cfg_nxt = cfg_r;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // axi4-lite read path
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = dofs_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                dofs_pkg::OFS_FUNC_SEL:  rdata_nxt[3:0]  = cfg_r.func_sel;
                dofs_pkg::OFS_UPPER_THR: rdata_nxt[15:0] = cfg_r.upper_switch_threshold;
                dofs_pkg::OFS_LOWER_THR: rdata_nxt[15:0] = cfg_r.lower_switch_threshold;
                dofs_pkg::OFS_RATED_CUR: rdata_nxt[15:0] = cfg_r.motor_rated_current;
                dofs_pkg::OFS_MAX_FREQ:  rdata_nxt[15:0] = cfg_r.max_freq;
                dofs_pkg::OFS_RATED_TRQ: rdata_nxt[15:0] = cfg_r.rated_trq;
                dofs_pkg::OFS_RATED_PWR: rdata_nxt[15:0] = cfg_r.rated_pwr;
                dofs_pkg::OFS_STATUS: begin
                    rdata_nxt[dofs_pkg::STS_DIG_BIT]  = dig_r;
                    rdata_nxt[dofs_pkg::STS_HYST_BIT] = hyst_state;
                    rdata_nxt[dofs_pkg::STS_BUSY_BIT] = scale_busy;
                end
                dofs_pkg::OFS_ANALOG:    rdata_nxt[15:0] = ana_r;
                default:                 rresp_nxt = dofs_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_r.func_sel               <= dofs_pkg::RST_FUNC_SEL;
            cfg_r.upper_switch_threshold <= dofs_pkg::RST_UPPER_THR;
            cfg_r.lower_switch_threshold <= dofs_pkg::RST_LOWER_THR;
            cfg_r.motor_rated_current    <= dofs_pkg::RST_RATED_CUR;
            cfg_r.max_freq               <= dofs_pkg::RST_MAX_FREQ;
            cfg_r.rated_trq              <= dofs_pkg::RST_RATED_TRQ;
            cfg_r.rated_pwr              <= dofs_pkg::RST_RATED_PWR;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= dofs_pkg::RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= dofs_pkg::RESP_OKAY;
            dig_r     <= 1'b0;
            ana_r     <= 16'h0000;
        end else begin
            cfg_r     <= cfg_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            dig_r     <= dig_nxt;
            ana_r     <= ana_nxt;
        end
    end

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign dig_out       = dig_r;
    assign ana_out       = ana_r;
endmodule : dofs_top

// >>> tb/dofs_chk.sv
`timescale 1ns/100ps
module dofs_chk (
    input wire logic                 clk_sys,
    input wire logic                 resetn,
    input wire dofs_pkg::dofs_meas_t meas,
    input wire logic                 dig_out,
    input wire logic [15:0]          ana_out,
    input wire logic [7:0]           s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic [31:0]          s_axi_wdata,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready
);
    logic [7:0]  a_r;
    logic [15:0] d_r, sg;
    logic [15:0] cf_r [3];
    logic [2:0]  st_r;
    wire tk = s_axi_awvalid && s_axi_awready;
    wire cm = s_axi_bvalid && s_axi_bready;
    wire [3:0] fs = cf_r[0][3:0];
    wire ok = st_r > 3'h2;
    wire hy = st_r > 3'h3 && fs[3:2] == 2'b01;
    // shadow copy of select and thresholds, settle count after any write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cf_r <= '{default: '0};
            st_r <= '0;
        end else begin
            if (tk) a_r <= s_axi_awaddr;
            if (tk) d_r <= s_axi_wdata[15:0];
            if (cm && a_r < 8'h0C) cf_r[a_r[3:2]] <= d_r;
            st_r <= (tk || cm) ? 3'h0 : st_r + 3'(st_r != 3'h7);
        end
    end
    always_comb begin
        case (fs)
            4'h4: sg = meas.out_freq;
            4'h5: sg = meas.motor_cur;
            4'h6: sg = meas.motor_trq;
            default: sg = meas.ain2;
        endcase
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_hi; hy && sg >= cf_r[1]; endsequence
    sequence s_lo; hy && sg < cf_r[2]; endsequence
    a_enabled_out: assert property (ok && fs == 4'h0 |-> dig_out == $past(meas.running))
        else $error("dig_out not following running");
    a_healthy_out: assert property (ok && fs == 4'h1 |-> dig_out == !$past(meas.fault))
        else $error("dig_out not following fault");
    a_target_out: assert property (ok && fs == 4'h2 |->
        dig_out == ($past(meas.out_freq) == $past(meas.set_freq)))
        else $error("dig_out wrong at target");
    a_running_out: assert property (ok && fs == 4'h3 |->
        dig_out == ($past(meas.out_freq) != '0))
        else $error("dig_out wrong for running");
    a_hyst_set: assert property (s_hi |=> ##1 dig_out)
        else $error("dig_out not set at upper");
    a_hyst_clr: assert property (s_lo |=> ##1 !dig_out)
        else $error("dig_out not cleared below lower");
    a_hyst_hold: assert property (hy && sg >= cf_r[2] && sg < cf_r[1] |=>
        ##1 $stable(dig_out))
        else $error("dig_out moved inside band");
    a_pid_copy: assert property (ok && fs == 4'hC |-> ana_out == $past(meas.pid_out))
        else $error("ana_out not pid value");
endmodule : dofs_chk

// >>> tb/drive_output_function_select_test.sv
`timescale 1ns/100ps
module drive_output_function_select_test;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    dofs_pkg::dofs_meas_t meas = '0;
    logic dig_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] ana_out;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0, samples_checked = 0, e;
    int xv [4] = '{500, 600, 400, 750};
    int fv [4] = '{1000, 2000, 2000, 1500};
    logic [15:0] lv [5] = '{16'h0063, 16'h0064, 16'h0032, 16'h0031, 16'h0063};
    logic [4:0] ev = 5'h06;
    dofs_top dut (.clk_sys, .resetn, .meas, .dig_out, .ana_out, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        samples_checked++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(r), 32'(s_axi_bresp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", x, s_axi_rdata);
        chk("rresp", 32'(r), 32'(s_axi_rresp));
    endtask : rd
    task automatic dchk(input logic x);
        repeat (4) @(posedge clk_sys);
        chk("dig_out", 32'(x), 32'(dig_out));
    endtask : dchk
    task automatic sig(input int c, input logic [15:0] v);
        case (c)
            4: meas.out_freq <= v;
            5: meas.motor_cur <= v;
            6: meas.motor_trq <= v;
            default: meas.ain2 <= v;
        endcase
    endtask : sig
    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        #1_000_000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(4 * i), '0, 2'h0);
        wr(8'h40, 32'h0000_0003, 2'h2);
        rd(8'h40, '0, 2'h2);
        wr(8'h1C, 32'h0000_0003, 2'h2);
        rd(8'h00, '0, 2'h0);
        meas.running <= 1'b1;
        dchk(1'b1);
        meas.running <= 1'b0;
        dchk(1'b0);
        wr(8'h00, 32'h0000_0001, 2'h0);
        meas.fault <= 1'b1;
        dchk(1'b0);
        meas.fault <= 1'b0;
        dchk(1'b1);
        wr(8'h00, 32'h0000_0002, 2'h0);
        meas.out_freq <= 16'h0064;
        meas.set_freq <= 16'h0064;
        dchk(1'b1);
        meas.set_freq <= 16'h0065;
        dchk(1'b0);
        wr(8'h00, 32'h0000_0003, 2'h0);
        dchk(1'b1);
        meas.out_freq <= 16'h0000;
        dchk(1'b0);
        wr(8'h04, 32'h0000_0064, 2'h0);
        wr(8'h08, 32'h0000_0032, 2'h0);
        for (int c = 4; c < 8; c++) begin
            wr(8'h00, 32'(c), 2'h0);
            for (int k = 0; k < 5; k++) begin
                sig(c, lv[k]);
                dchk(ev[k]);
                if (ev[k]) rd(8'h1C, 32'h0000_0003, 2'h0);
            end
        end
        for (int i = 3; i < 7; i++) wr(8'(4 * i), 32'h0000_03E8, 2'h0);
        rd(8'h0C, 32'h0000_03E8, 2'h0);
        meas.out_freq <= 16'(xv[0]);
        meas.motor_cur <= 16'(xv[1]);
        meas.motor_trq <= 16'(xv[2]);
        meas.out_pwr <= 16'(xv[3]);
        for (int c = 8; c < 12; c++) begin
            wr(8'h00, 32'(c), 2'h0);
            repeat (40) @(posedge clk_sys);
            e = xv[c - 8] * 65536 / fv[c - 8];
            chk("ana_out", 32'(e), 32'(ana_out));
            chk("dig_out", '0, 32'(dig_out));
        end
        wr(8'h00, 32'h0000_0009, 2'h0);
        meas.motor_cur <= 16'h0FA0;
        repeat (40) @(posedge clk_sys);
        chk("ana_sat", 32'h0000_FFFF, 32'(ana_out));
        wr(8'h00, 32'h0000_000C, 2'h0);
        meas.pid_out <= 16'h1234;
        repeat (3) @(posedge clk_sys);
        chk("ana_pid", 32'h0000_1234, 32'(ana_out));
        rd(8'h20, 32'h0000_1234, 2'h0);
        wr(8'h00, 32'h0000_000F, 2'h0);
        dchk(1'b0);
        chk("ana_off", '0, 32'(ana_out));
        report_and_stop();
    end
endmodule : drive_output_function_select_test
bind dofs_top dofs_chk u_chk (.clk_sys, .resetn, .meas, .dig_out, .ana_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready);
